/* File: dwd_defs.svh */
// Purpose: Field positions, widths and reset values for the DAC write decoder.
// Assumes: The command word arrives whole, already deserialised.
// Notes:   Definitions only; included by the decoder and the corrector.
//
// What this block does
// - Channel bits 27..24 plus kind bits 23..22 select gain, offset or input.
// - Each set channel bit gets the write, except shared offset DAC writes; any combination of channels allowed.
// - Six address bits 21..16 pick which DAC level is written.
// - Lowest sixteen bits of a DAC write are stored as DAC data.
// - Data field MSB is bit 15, LSB is bit 0.
// - Kind 01 is gain, 10 is offset, 11 is input register.
// - Corrected code is recomputed only on input register writes.
// - One shared offset DAC, any channel bit, input register address 0, kind 11.
`ifndef DWD_DEFS_SVH
`define DWD_DEFS_SVH

`define DWD_WORD_W      29
`define DWD_RW_BIT      28
`define DWD_MASK_HI     27
`define DWD_MASK_LO     24
`define DWD_KIND_HI     23
`define DWD_KIND_LO     22
`define DWD_ADDR_HI     21
`define DWD_ADDR_LO     16
`define DWD_DATA_HI     15
`define DWD_DATA_LO     0
`define DWD_SYS_HI      21
`define DWD_NUM_CH      4
`define DWD_NUM_ADDR    64
`define DWD_OFFDAC_ADDR 6'h00
`define DWD_GAIN_RST    16'hFFFF
`define DWD_OFFS_RST    16'h8000
`define DWD_MID_CODE    19'h0_8000
`define DWD_FULL_CODE   19'h0_FFFF
`define DWD_MAX_DATA    16'hFFFF
`define DWD_ZERO_DATA   16'h0000

`endif

/* File: dwd_pkg.sv */
// Purpose: Shared types of the DAC write decoder.
// Assumes: Nothing beyond the constants header.
// Notes:   Kind codes follow the two register-kind bits, upper bit first.
package dwd_pkg;
   typedef enum logic [1:0] {
      DWD_KIND_CTRL  = 2'b00,
      DWD_KIND_GAIN  = 2'b01,
      DWD_KIND_OFFS  = 2'b10,
      DWD_KIND_INPUT = 2'b11
   } dwd_kind_t;
endpackage : dwd_pkg

/* File: dwd_corrector.sv */
// Purpose: Computes one channel's corrected DAC code from input, gain, offset.
// Assumes: start is a one-cycle pulse with operands stable in that cycle.
// Notes:   Result is clamped to the code range and held until the next start.
`timescale 1ns/1ps
`include "dwd_defs.svh"
module dwd_corrector (
   input  wire logic        clk,      // 40 MHz clock
   input  wire logic        rst_n,    // Synchronous reset, active low
   input  wire logic        start,    // Recompute strobe
   input  wire logic [15:0] inCode,   // Input register value
   input  wire logic [15:0] gainCode, // Gain register value
   input  wire logic [15:0] offsCode, // Offset register value
   output logic      [15:0] corrCode, // Corrected code
   output logic             corrValid // Pulse when corrCode updates
);
   // ==========================================================
   // Arithmetic
   // Gain scales by (m+1)/2^16 so full-scale gain is unity.
   wire logic [32:0] product = inCode * {1'b0, gainCode} + {17'h0_0000, inCode};
   wire logic [18:0] summed  = {2'b00, product[32:16]} + {3'b000, offsCode};
   wire logic        under   = summed < `DWD_MID_CODE;
   wire logic [18:0] shifted = summed - `DWD_MID_CODE;
   wire logic        over    = shifted > `DWD_FULL_CODE;
   wire logic [15:0] result  = under ? `DWD_ZERO_DATA :
                               over  ? `DWD_MAX_DATA  : shifted[15:0];

   // ==========================================================
   // Result register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         corrCode  <= `DWD_ZERO_DATA;
         corrValid <= 1'b0;
      end else begin
         corrValid <= start;
         if (start) begin
            corrCode <= result;
         end
      end
   end
endmodule : dwd_corrector

/* File: dwd_decoder.sv */
// Purpose: Decodes a DAC write command word into per-channel register writes.
// Assumes: cmdValid marks one complete 29-bit word, synchronous to clk.
// Notes:   All strobes and data appear one cycle after the word is taken.
`timescale 1ns/1ps
`include "dwd_defs.svh"
module dwd_decoder (
   input  wire logic                    clk,         // 40 MHz clock
   input  wire logic                    rst_n,       // Sync reset, low
   input  wire logic                    cmdValid,    // Word present pulse
   input  wire logic [`DWD_WORD_W-1:0]  cmdWord,     // Command word
   output logic      [3:0]              gainWr,      // Gain write per ch
   output logic      [3:0]              offsWr,      // Offset write per ch
   output logic      [3:0]              inWr,        // Input write per ch
   output logic                         offDacWr,    // Shared offset DAC write
   output logic      [15:0]             offDacCode,  // Shared offset DAC code
   output logic                         sysCtrlWr,   // System control write
   output logic      [3:0]              pmuRegWr,    // Channel register write
   output logic      [21:0]             ctrlData,    // Control write payload
   output logic      [5:0]              dacAddr,     // Addressed DAC level
   output logic      [15:0]             dacData,     // Written DAC data
   output logic      [3:0]              corrValid,   // Corrected code pulse
   output logic      [63:0]             corrCode,    // Corrected codes, ch3..0
   output logic                         readReq,     // Readback request
   output logic      [`DWD_WORD_W-1:0]  readWord,    // Readback command
   output logic      [15:0]             readData     // Readback DAC contents
);
   import dwd_pkg::*;

   // ==========================================================
   // Field extraction
   function automatic logic [1:0] lowestChan(input logic [3:0] m);
      lowestChan = m[0] ? 2'd0 : m[1] ? 2'd1 : m[2] ? 2'd2 : 2'd3;
   endfunction : lowestChan

   function automatic logic isWriteOf(input logic v, input logic rd,
                                      input dwd_kind_t k,
                                      input dwd_kind_t want);
      isWriteOf = v && !rd && (k == want);
   endfunction : isWriteOf

   wire logic        cmdRead = cmdWord[`DWD_RW_BIT];
   wire logic [3:0]  cmdMask = cmdWord[`DWD_MASK_HI:`DWD_MASK_LO];
   wire dwd_kind_t   cmdKind = dwd_kind_t'(cmdWord[`DWD_KIND_HI:`DWD_KIND_LO]);
   wire logic [5:0]  cmdAddr = cmdWord[`DWD_ADDR_HI:`DWD_ADDR_LO];
   // Data field, MSB at bit 15
   wire logic [15:0] cmdData = cmdWord[`DWD_DATA_HI:`DWD_DATA_LO];
   wire logic [21:0] cmdCtrl = cmdWord[`DWD_SYS_HI:0];

   wire logic isGain  = isWriteOf(cmdValid, cmdRead, cmdKind, DWD_KIND_GAIN);
   wire logic isOffs  = isWriteOf(cmdValid, cmdRead, cmdKind, DWD_KIND_OFFS);
   wire logic isInput = isWriteOf(cmdValid, cmdRead, cmdKind, DWD_KIND_INPUT);
   wire logic isCtrl  = isWriteOf(cmdValid, cmdRead, cmdKind, DWD_KIND_CTRL);
   wire logic isOffDac = isInput && (cmdMask != 4'h0)
                         && (cmdAddr == `DWD_OFFDAC_ADDR);
   wire logic isChanIn = isInput && !isOffDac;
   wire logic isSys    = isCtrl && (cmdMask == 4'h0);
   wire logic isPmu    = isCtrl && (cmdMask != 4'h0);
   wire logic isRead   = cmdValid && cmdRead;

   // ==========================================================
   // Register arrays
   logic [15:0] gainMem [0:`DWD_NUM_CH-1][0:`DWD_NUM_ADDR-1];
   logic [15:0] offsMem [0:`DWD_NUM_CH-1][0:`DWD_NUM_ADDR-1];
   logic [15:0] inMem   [0:`DWD_NUM_CH-1][0:`DWD_NUM_ADDR-1];
   logic [15:0] offDac_q;

   always_ff @(posedge clk) begin
      for (int c = 0; c < `DWD_NUM_CH; c++) begin
         if (cmdMask[c] && isGain) begin
            gainMem[c][cmdAddr] <= cmdData;
         end
         if (cmdMask[c] && isOffs) begin
            offsMem[c][cmdAddr] <= cmdData;
         end
         if (cmdMask[c] && isChanIn) begin
            inMem[c][cmdAddr] <= cmdData;
         end
      end
   end

   // Coefficient registers are volatile; without a reset they would start
   // undefined, so the first write to each location is tracked here.
   logic [`DWD_NUM_ADDR-1:0] gainSet_q [0:`DWD_NUM_CH-1];
   logic [`DWD_NUM_ADDR-1:0] offsSet_q [0:`DWD_NUM_CH-1];

   always_ff @(posedge clk) begin
      for (int c = 0; c < `DWD_NUM_CH; c++) begin
         if (!rst_n) begin
            gainSet_q[c] <= '0;
            offsSet_q[c] <= '0;
         end else begin
            if (cmdMask[c] && isGain) begin
               gainSet_q[c][cmdAddr] <= 1'b1;
            end
            if (cmdMask[c] && isOffs) begin
               offsSet_q[c][cmdAddr] <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Correction per channel
   genvar g;
   generate
      for (g = 0; g < `DWD_NUM_CH; g++) begin : gCh
         wire logic [15:0] gainNow = gainSet_q[g][cmdAddr]
                                     ? gainMem[g][cmdAddr] : `DWD_GAIN_RST;
         wire logic [15:0] offsNow = offsSet_q[g][cmdAddr]
                                     ? offsMem[g][cmdAddr] : `DWD_OFFS_RST;
         wire logic        kick    = cmdMask[g] && isChanIn;
         dwd_corrector uCorr (
            .clk       (clk),
            .rst_n     (rst_n),
            .start     (kick),
            .inCode    (cmdData),
            .gainCode  (gainNow),
            .offsCode  (offsNow),
            .corrCode  (corrCode[16*g +: 16]),
            .corrValid (corrValid[g])
         );
      end
   endgenerate

   // ==========================================================
   // Readback selection
   wire logic [1:0]  rdCh     = lowestChan(cmdMask);
   // Unwritten coefficients read back as their power-up defaults.
   wire logic [15:0] rdGain   = gainSet_q[rdCh][cmdAddr]
                                ? gainMem[rdCh][cmdAddr] : `DWD_GAIN_RST;
   wire logic [15:0] rdOffs   = offsSet_q[rdCh][cmdAddr]
                                ? offsMem[rdCh][cmdAddr] : `DWD_OFFS_RST;
   wire logic        rdOffDac = (cmdKind == DWD_KIND_INPUT)
                                && (cmdAddr == `DWD_OFFDAC_ADDR);
   wire logic [15:0] rdSel    =
      (cmdMask == 4'h0)             ? `DWD_ZERO_DATA :
      (cmdKind == DWD_KIND_GAIN)    ? rdGain :
      (cmdKind == DWD_KIND_OFFS)    ? rdOffs :
      rdOffDac                      ? offDac_q :
      (cmdKind == DWD_KIND_INPUT)   ? inMem[rdCh][cmdAddr] : `DWD_ZERO_DATA;

   // ==========================================================
   // Output registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gainWr    <= 4'h0;
         offsWr    <= 4'h0;
         inWr      <= 4'h0;
         offDacWr  <= 1'b0;
         sysCtrlWr <= 1'b0;
         pmuRegWr  <= 4'h0;
         readReq   <= 1'b0;
      end else begin
         gainWr    <= isGain   ? cmdMask : 4'h0;
         offsWr    <= isOffs   ? cmdMask : 4'h0;
         inWr      <= isChanIn ? cmdMask : 4'h0;
         offDacWr  <= isOffDac;
         sysCtrlWr <= isSys;
         pmuRegWr  <= isPmu    ? cmdMask : 4'h0;
         readReq   <= isRead;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         offDac_q <= `DWD_OFFS_RST;
         dacAddr  <= 6'h00;
         dacData  <= `DWD_ZERO_DATA;
         ctrlData <= 22'h00_0000;
         readWord <= '0;
         readData <= `DWD_ZERO_DATA;
      end else begin
         if (isOffDac) begin
            offDac_q <= cmdData;
         end
         if (isGain || isOffs || isInput) begin
            dacAddr <= cmdAddr;
            dacData <= cmdData;
         end
         if (isCtrl) begin
            ctrlData <= cmdCtrl;
         end
         if (isRead) begin
            readWord <= cmdWord;
            readData <= rdSel;
         end
      end
   end

   assign offDacCode = offDac_q;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence sWr(dwd_kind_t k);
      cmdValid && !cmdRead && cmdKind == k;
   endsequence

   sequence sRead;
      cmdValid && cmdRead;
   endsequence

   AST_GAIN_ROUTE: assert property (
      sWr(DWD_KIND_GAIN) |=> gainWr == $past(cmdMask) && inWr == 4'h0)
      else $error("Gain write not routed to selected channels.");

   AST_OFFS_ROUTE: assert property (
      sWr(DWD_KIND_OFFS) |=> offsWr == $past(cmdMask) && gainWr == 4'h0)
      else $error("Offset write not routed to selected channels.");

   AST_SYS_CTRL: assert property (
      sWr(DWD_KIND_CTRL) ##0 (cmdMask == 4'h0)
      |=> sysCtrlWr && pmuRegWr == 4'h0 && ctrlData == $past(cmdCtrl))
      else $error("Control write with empty mask missed system control.");

   AST_PMU_REG: assert property (
      sWr(DWD_KIND_CTRL) ##0 (cmdMask != 4'h0)
      |=> !sysCtrlWr && pmuRegWr == $past(cmdMask))
      else $error("Channel register write not routed.");

   AST_ADDR_DATA: assert property (
      (isGain || isOffs || isInput)
      |=> dacAddr == $past(cmdAddr) && dacData == $past(cmdData))
      else $error("DAC address or data not captured.");

   AST_DATA_BITS: assert property (
      isOffDac |=> offDacWr && offDacCode == $past(cmdWord[15:0]))
      else $error("Offset DAC did not store the low sixteen bits.");

   AST_OFFDAC_ONLY: assert property (
      isOffDac |=> inWr == 4'h0 && corrValid == 4'h0)
      else $error("Shared offset DAC write leaked to channel registers.");

   AST_RECALC: assert property (
      (isGain || isOffs) |=> corrValid == 4'h0)
      else $error("Gain or offset write triggered a recalculation.");

   AST_RECALC_IN: assert property (
      isChanIn |=> corrValid == $past(cmdMask))
      else $error("Input write did not recompute selected channels.");

   AST_READ_NOWR: assert property (
      sRead |=> readReq && gainWr == 4'h0 && offsWr == 4'h0
                && inWr == 4'h0 && !sysCtrlWr && readWord == $past(cmdWord))
      else $error("Read command caused a write or lost the request.");

   AST_MSB_POS: assert property (
      isInput && cmdWord[15] |=> dacData[15])
      else $error("Data MSB not taken from bit 15.");
endmodule : dwd_decoder

/* File: dwd_host_model.sv */
// Purpose: Host controller model that frames command words for the decoder.
// Assumes: The bench holds each request from one rising edge to the next.
// Notes:   Between words the data lines toggle every cycle, so an idle
//          word alternates between the inverse of the last real one and that word.
`timescale 1ns/1ps
module dwd_host_model (
   input  wire logic        clk,      // 40 MHz clock
   input  wire logic        sendEn,   // Send a word this cycle
   input  wire logic        sendRead, // Read flag
   input  wire logic [3:0]  sendMask, // Channel mask
   input  wire logic [1:0]  sendKind, // Register kind
   input  wire logic [5:0]  sendAddr, // Level address
   input  wire logic [15:0] sendData, // DAC data
   output logic             cmdValid, // Word present
   output logic      [28:0] cmdWord   // Command word
);
   initial cmdWord = 29'h0000_0000;
   // =====================================================================
   // Word framing
   // Read flag on top.
   always @(posedge clk) begin
      cmdValid <= sendEn;
      cmdWord  <= sendEn ? {sendRead, sendMask, sendKind, sendAddr, sendData}
                         : ~cmdWord;
   end
endmodule : dwd_host_model

/* File: tb.sv */
// Purpose: Self-checking bench for the DAC write decoder.
// Assumes: The host model turns field requests into one word a cycle.
// Notes:   Expected strobes and codes are worked out here from the fields.
`timescale 1ns/1ps
module tb;
   logic        clk, rst_n, sendEn, sendRead, cmdValid;
   logic        offDacWr, sysCtrlWr, readReq;
   logic [3:0]  sendMask, gainWr, offsWr, inWr, pmuRegWr, corrValid, lastIn;
   logic [1:0]  sendKind;
   logic [5:0]  sendAddr, dacAddr;
   logic [15:0] sendData, offDacCode, dacData, readData;
   logic [15:0] offDacM;
   logic [15:0] gain [4];
   logic [15:0] offs [4];
   logic [15:0] inReg [4];
   logic [28:0] cmdWord, readWord;
   logic [21:0] ctrlData;
   logic [63:0] corrCode;
   logic [3:0]  masks [5] = '{4'h0, 4'h1, 4'h6, 4'hF, 4'hA};
   int          n_mismatch = 0;
   int          comparisons = 0;
   int          cyc = 0;

   dwd_host_model uHost (.clk(clk), .sendEn(sendEn), .sendRead(sendRead),
      .sendMask(sendMask), .sendKind(sendKind), .sendAddr(sendAddr),
      .sendData(sendData), .cmdValid(cmdValid), .cmdWord(cmdWord));
   dwd_decoder uut (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid),
      .cmdWord(cmdWord), .gainWr(gainWr), .offsWr(offsWr), .inWr(inWr),
      .offDacWr(offDacWr), .offDacCode(offDacCode), .sysCtrlWr(sysCtrlWr),
      .pmuRegWr(pmuRegWr), .ctrlData(ctrlData), .dacAddr(dacAddr),
      .dacData(dacData), .corrValid(corrValid), .corrCode(corrCode),
      .readReq(readReq), .readWord(readWord), .readData(readData));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // A hang counts as a mismatch; the run needs about 130 cycles.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         complete_run();
      end
   end

   // =====================================================================
   // Comparison and closing
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run

   // =====================================================================
   // Command access
   task automatic put(input logic rd, input logic [3:0] m,
                      input logic [1:0] k, input logic [5:0] a,
                      input logic [15:0] d);
      sendEn   <= 1'b1;
      sendRead <= rd;
      sendMask <= m;
      sendKind <= k;
      sendAddr <= a;
      sendData <= d;
   endtask : put
   task automatic expectOut(input logic rd, input logic [3:0] m,
                            input logic [1:0] k, input logic [5:0] a,
                            input logic [15:0] d);
      logic wr, isIn, isOff;
      int   lo;
      wr    = !rd;
      isOff = wr && k == 2'b11 && a == 6'h00;
      isIn  = wr && k == 2'b11 && a != 6'h00;
      lo    = 0;
      for (int c = 3; c >= 0; c--) if (m[c]) lo = c;
      chk(gainWr, (wr && k == 2'b01) ? m : 4'h0);
      chk(offsWr, (wr && k == 2'b10) ? m : 4'h0);
      chk(inWr, isIn ? m : 4'h0);
      chk(offDacWr, isOff && m != 4'h0);
      chk(sysCtrlWr, wr && k == 2'b00 && m == 4'h0);
      chk(pmuRegWr, (wr && k == 2'b00) ? m : 4'h0);
      chk(readReq, rd);
      if (rd) chk(readWord, {rd, m, k, a, d});
      if (wr && k != 2'b00) chk(dacAddr, a);
      if (wr && k != 2'b00) chk(dacData, d);
      if (wr && k == 2'b00) chk(ctrlData, {a, d});
      if (isOff && m != 4'h0) chk(offDacCode, d);
      if (rd) chk(readData, (m == 4'h0 || k == 2'b00) ? 16'h0000 :
         k == 2'b01 ? gain[lo] : k == 2'b10 ? offs[lo] :
         a == 6'h00 ? offDacM : inReg[lo]);
      if (isOff && m != 4'h0) offDacM = d;
      for (int c = 0; c < 4; c++) begin
         if (m[c] && wr && k == 2'b01) gain[c] = d;
         if (m[c] && wr && k == 2'b10) offs[c] = d;
         if (m[c] && isIn) inReg[c] = d;
      end
      lastIn = isIn ? m : 4'h0;
   endtask : expectOut
   task automatic expectCorr();
      longint t;
      chk(corrValid, lastIn);
      for (int c = 0; c < 4; c++) begin
         t = longint'(inReg[c]) * (longint'(gain[c]) + 1) / 65536;
         t = t + longint'(offs[c]) - 32768;
         if (t < 0) t = 0;
         if (t > 65535) t = 65535;
         if (lastIn[c]) chk(corrCode[c*16 +: 16], t[15:0]);
      end
   endtask : expectCorr
   task automatic issue(input logic rd, input logic [3:0] m,
                        input logic [1:0] k, input logic [5:0] a,
                        input logic [15:0] d);
      put(rd, m, k, a, d);
      @(posedge clk);
      sendEn <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      // The corrected code lands together with the write strobes.
      expectOut(rd, m, k, a, d);
      expectCorr();
      @(posedge clk);
   endtask : issue

   // =====================================================================
   // Test sequence
   initial begin
      rst_n = 1'b0;
      sendEn = 1'b0;
      sendRead = 1'b0;
      sendMask = 4'h0;
      sendKind = 2'b00;
      sendAddr = 6'h00;
      sendData = 16'h0000;
      lastIn = 4'h0;
      offDacM = 16'h8000;
      for (int c = 0; c < 4; c++) begin
         gain[c] = 16'hFFFF;
         offs[c] = 16'h8000;
         inReg[c] = 16'h0000;
      end
      repeat (20) @(posedge clk);
      @(negedge clk);
      chk(offDacCode, 16'h8000);
      chk(corrCode, 64'h0000_0000_0000_0000);
      chk(dacData, 16'h0000);
      @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // Unwritten coefficients must read back as their defaults.
      for (int k = 1; k < 3; k++) issue(1'b1, 4'h1, k[1:0], 6'h08,
                                       16'h0000);
      for (int k = 0; k < 4; k++) begin
         for (int i = 0; i < 5; i++) begin
            issue(1'b0, masks[i], k[1:0], 6'h08,
                  16'h3A00 + 16'(k * 8448 + i * 3125));
         end
      end
      issue(1'b0, 4'h0, 2'b01, 6'h3F, 16'hBEEF);
      issue(1'b0, 4'h3, 2'b10, 6'h08, 16'h0000);
      issue(1'b0, 4'h3, 2'b11, 6'h08, 16'h0010);
      issue(1'b0, 4'h4, 2'b01, 6'h08, 16'hFFFF);
      issue(1'b0, 4'h4, 2'b10, 6'h08, 16'hFFFF);
      issue(1'b0, 4'h4, 2'b11, 6'h08, 16'hFFFF);
      issue(1'b0, 4'h2, 2'b11, 6'h00, 16'h1234);
      issue(1'b0, 4'h0, 2'b11, 6'h00, 16'h5678);
      chk(offDacCode, 16'h1234);
      for (int k = 0; k < 4; k++) issue(1'b1, 4'h6, k[1:0], 6'h08,
                                       16'h0000);
      issue(1'b1, 4'h2, 2'b11, 6'h00, 16'h0000);
      put(1'b0, 4'h8, 2'b01, 6'h08, 16'h9000);
      @(posedge clk);
      put(1'b0, 4'h8, 2'b11, 6'h08, 16'h8001);
      @(posedge clk);
      sendEn <= 1'b0;
      @(negedge clk);
      expectOut(1'b0, 4'h8, 2'b01, 6'h08, 16'h9000);
      expectCorr();
      @(negedge clk);
      expectOut(1'b0, 4'h8, 2'b11, 6'h08, 16'h8001);
      expectCorr();
      complete_run();
   end
endmodule : tb
